/* File: hdl/pife_top.sv */
// Peripheral interrupt enable and flag registers with group and global gating toward the core.
`timescale 1ns/10ps
module pife_top (
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Register port.
  input  wire logic [pife_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pife_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pife_pkg::DATA_W-1:0] reg_rdata,
  // One-cycle event pulses from on-chip peripherals.
  input  wire logic                        adc_done,
  input  wire logic                        serial_port_event,
  input  wire logic                        bus_collision_event,
  input  wire logic                        timer_two_match,
  input  wire logic                        timer_one_rollover,
  // Asynchronous fault levels from the analog front end.
  input  wire logic                        out_undervolt,
  input  wire logic                        out_overcurrent,
  input  wire logic                        out_overvolt,
  input  wire logic                        supply_low,
  // Core handshake for entry to and return from the service routine.
  input  wire logic                        core_irq_taken,
  input  wire logic                        core_irq_return,
  // Requests toward the core and the fault interrupt.
  output logic                             periph_req,
  output logic                             core_irq_req,
  output logic                             fault_irq
);
  import pife_pkg::*;

  typedef struct packed {
    logic       global_irq_enable;
    logic       peripheral_group_enable;
    logic [7:0] peripheral_enable_one;
    logic [7:0] peripheral_enable_two;
    logic [7:0] peripheral_flag_one;
    logic [7:0] peripheral_flag_two;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [3:0] level_prev;
    logic [7:0] rdata;
    logic       periph_req;
    logic       core_req;
    logic       fault_irq;
  } pife_state_t;

  pife_state_t state_reg;
  pife_state_t state_next;

  logic [3:0] fault_level;
  logic [3:0] fault_rise;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic       wr_ctrl;
  logic       wr_en_one;
  logic       wr_en_two;
  logic       wr_flag_one;
  logic       wr_flag_two;
  logic       wr_stat;
  logic       wr_mask;

  // Write value for a software-writable flag register; the hardware set is ORed last so it wins.
  function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic wr, input logic [7:0] wdata,
                                             input logic [7:0] set, input logic [7:0] mask);
    logic [7:0] base;
    base = wr ? wdata : cur;
    return (base | set) & mask;
  endfunction

  // Write-one-to-clear update, again with the hardware set taking priority.
  function automatic logic [7:0] w1c_update(input logic [7:0] cur, input logic wr, input logic [7:0] wdata,
                                            input logic [7:0] set, input logic [7:0] mask);
    logic [7:0] clr;
    clr = wr ? wdata : 8'h00;
    return ((cur & ~clr) | set) & mask;
  endfunction

  // Request term: any flag whose own enable is set.
  function automatic logic any_pending(input logic [7:0] flg1, input logic [7:0] en1,
                                       input logic [7:0] flg2, input logic [7:0] en2);
    return |((flg1 & en1) | (flg2 & en2));
  endfunction

  // The fault levels come from analog comparators, so they are synchronised before use.
  pife_sync3 #(
    .WIDTH (4)
  ) u_fault_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .async_in  ({supply_low, out_overvolt, out_overcurrent, out_undervolt}),
    .level_out (fault_level)
  );

  // Write strobe decode.
  assign wr_ctrl     = reg_wr && (reg_addr == OFF_INT_CTRL);
  assign wr_en_one   = reg_wr && (reg_addr == OFF_EN_ONE);
  assign wr_en_two   = reg_wr && (reg_addr == OFF_EN_TWO);
  assign wr_flag_one = reg_wr && (reg_addr == OFF_FLAG_ONE);
  assign wr_flag_two = reg_wr && (reg_addr == OFF_FLAG_TWO);
  assign wr_stat     = reg_wr && (reg_addr == OFF_EVT_STAT);
  assign wr_mask     = reg_wr && (reg_addr == OFF_EVT_MASK);

  // Rising edges of the synchronised fault levels feed the fault event status.
  assign fault_rise = fault_level & ~state_reg.level_prev;

  // Hardware set terms, independent of every enable bit.
  always_comb
  begin
    set_one                = 8'h00;
    set_one[BIT_ADC]       = adc_done;
    set_one[BIT_BUS_COLL]  = bus_collision_event;
    set_one[BIT_SERIAL]    = serial_port_event;
    set_one[BIT_TIMER_TWO] = timer_two_match;
    set_one[BIT_TIMER_ONE] = timer_one_rollover;
    set_two                = 8'h00;
    set_two[BIT_OUT_UV]    = fault_level[EVT_UV];
    set_two[BIT_OUT_OC]    = fault_level[EVT_OC];
    set_two[BIT_OUT_OV]    = fault_level[EVT_OV];
  end

  // Next-state logic for all registers and registered outputs.
  always_comb
  begin
    state_next = state_reg;

    // Global enable: the core clears it on entry and sets it on return, software may write it.
    if (wr_ctrl)
    begin
      state_next.global_irq_enable       = reg_wdata[BIT_GLOBAL_EN];
      state_next.peripheral_group_enable = reg_wdata[BIT_GROUP_EN];
    end
    if (core_irq_return)
    begin
      state_next.global_irq_enable = 1'b1;
    end
    if (core_irq_taken)
    begin
      state_next.global_irq_enable = 1'b0;
    end

    // Enable registers keep only their implemented bits.
    if (wr_en_one)
    begin
      state_next.peripheral_enable_one = reg_wdata & MASK_ONE;
    end
    if (wr_en_two)
    begin
      state_next.peripheral_enable_two = reg_wdata & MASK_TWO;
    end

    // Flags set on events whatever the enables say; a same-cycle clear loses.
    state_next.peripheral_flag_one = flag_update(state_reg.peripheral_flag_one, wr_flag_one,
                                                 reg_wdata, set_one, MASK_ONE);
    state_next.peripheral_flag_two = flag_update(state_reg.peripheral_flag_two, wr_flag_two,
                                                 reg_wdata, set_two, MASK_FLAG_TWO);
    // The supply bit is a live status, so software writes to it have no effect.
    state_next.peripheral_flag_two[BIT_SUPPLY] = fault_level[EVT_SUPPLY];

    // Fault event status and mask for the fault interrupt line.
    state_next.evt_status = w1c_update(state_reg.evt_status, wr_stat, reg_wdata,
                                       {4'h0, fault_rise}, MASK_EVT);
    if (wr_mask)
    begin
      state_next.evt_mask = reg_wdata & MASK_EVT;
    end
    state_next.level_prev = fault_level;

    // Read data stands only in the cycle after the read strobe.
    state_next.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_INT_CTRL:
        begin
          state_next.rdata[BIT_GLOBAL_EN] = state_reg.global_irq_enable;
          state_next.rdata[BIT_GROUP_EN]  = state_reg.peripheral_group_enable;
        end
        OFF_EN_ONE:   state_next.rdata = state_reg.peripheral_enable_one;
        OFF_EN_TWO:   state_next.rdata = state_reg.peripheral_enable_two;
        OFF_FLAG_ONE: state_next.rdata = state_reg.peripheral_flag_one;
        OFF_FLAG_TWO: state_next.rdata = state_reg.peripheral_flag_two;
        OFF_EVT_STAT: state_next.rdata = state_reg.evt_status;
        OFF_EVT_MASK: state_next.rdata = state_reg.evt_mask;
        default:      state_next.rdata = 8'h00;
      endcase
    end

    // Outputs are formed from next values so each output agrees with the registers beside it.
    state_next.periph_req = state_next.peripheral_group_enable &&
                            any_pending(state_next.peripheral_flag_one, state_next.peripheral_enable_one,
                                        state_next.peripheral_flag_two, state_next.peripheral_enable_two);
    state_next.core_req   = state_next.periph_req && state_next.global_irq_enable;
    state_next.fault_irq  = |(state_next.evt_status & state_next.evt_mask);
  end

  // State register; every enable and flag clears on reset, including the global enable.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata    = state_reg.rdata;
  assign periph_req   = state_reg.periph_req;
  assign core_irq_req = state_reg.core_req;
  assign fault_irq    = state_reg.fault_irq;

  // Checks on the registered behaviour; all belong to the one clock domain.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_group_gate:
    assert property (periph_req == (state_reg.peripheral_group_enable &&
                     any_pending(state_reg.peripheral_flag_one, state_reg.peripheral_enable_one,
                                 state_reg.peripheral_flag_two, state_reg.peripheral_enable_two)))
    else $error("Peripheral request does not match gated flag and enable terms.");

  a_global_gate:
    assert property (core_irq_req |-> (state_reg.global_irq_enable && periph_req))
    else $error("Core request raised without global enable or peripheral request.");

  a_adc_flag_set:
    assert property (adc_done |=> state_reg.peripheral_flag_one[BIT_ADC])
    else $error("ADC done did not set its flag.");

  a_timer_two_set:
    assert property (timer_two_match && !state_reg.peripheral_enable_one[BIT_TIMER_TWO]
                     |=> state_reg.peripheral_flag_one[BIT_TIMER_TWO])
    else $error("Timer two match did not set its flag while disabled.");

  a_timer_one_hold:
    assert property (state_reg.peripheral_flag_one[BIT_TIMER_ONE] &&
                     !(wr_flag_one && !reg_wdata[BIT_TIMER_ONE])
                     |=> state_reg.peripheral_flag_one[BIT_TIMER_ONE])
    else $error("Timer one flag dropped without a software clear.");

  a_set_wins:
    assert property (serial_port_event && wr_flag_one && !reg_wdata[BIT_SERIAL]
                     |=> state_reg.peripheral_flag_one[BIT_SERIAL])
    else $error("Serial port event lost against a same-cycle clear.");

  a_enable_one_map:
    assert property (wr_en_one |=> state_reg.peripheral_enable_one == ($past(reg_wdata) & MASK_ONE))
    else $error("First enable register layout is wrong.");

  a_enable_two_map:
    assert property (wr_en_two |=> state_reg.peripheral_enable_two == ($past(reg_wdata) & MASK_TWO))
    else $error("Second enable register layout is wrong.");

  a_unimpl_zero:
    assert property (reg_rd && (reg_addr == OFF_FLAG_TWO || reg_addr == OFF_FLAG_ONE)
                     |=> (reg_rdata & ~(($past(reg_addr) == OFF_FLAG_ONE) ? MASK_ONE : MASK_TWO)) == 8'h00)
    else $error("Unimplemented flag bits read as one.");

  a_supply_level:
    assert property (state_reg.peripheral_flag_two[BIT_SUPPLY] == $past(fault_level[EVT_SUPPLY]))
    else $error("Supply status bit does not follow the supply level.");

  // A software clear one cycle after the level falls is legal, so only that case may drop the flag.
  a_fault_latch:
    assert property (fault_level[EVT_OC] |=> state_reg.peripheral_flag_two[BIT_OUT_OC] ##1
                     (state_reg.peripheral_flag_two[BIT_OUT_OC] || $past(wr_flag_two && !reg_wdata[BIT_OUT_OC])))
    else $error("Overcurrent error was not latched.");

endmodule

/* File: include/pife_pkg.sv */
// Package with the register map, field positions and reset values of the peripheral interrupt block.
package pife_pkg;

  // Register port widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets on the register port.
  localparam logic [3:0] OFF_INT_CTRL  = 4'h0;
  localparam logic [3:0] OFF_EN_ONE    = 4'h1;
  localparam logic [3:0] OFF_EN_TWO    = 4'h2;
  localparam logic [3:0] OFF_FLAG_ONE  = 4'h3;
  localparam logic [3:0] OFF_FLAG_TWO  = 4'h4;
  localparam logic [3:0] OFF_EVT_STAT  = 4'h5;
  localparam logic [3:0] OFF_EVT_MASK  = 4'h6;

  // Field positions of the interrupt control register.
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_GROUP_EN  = 6;

  // Field positions shared by the first enable and flag registers.
  localparam int BIT_ADC       = 6;
  localparam int BIT_BUS_COLL  = 5;
  localparam int BIT_SERIAL    = 4;
  localparam int BIT_TIMER_TWO = 1;
  localparam int BIT_TIMER_ONE = 0;

  // Field positions shared by the second enable and flag registers.
  localparam int BIT_OUT_UV    = 7;
  localparam int BIT_OUT_OC    = 5;
  localparam int BIT_OUT_OV    = 4;
  localparam int BIT_SUPPLY    = 1;

  // Field positions of the fault event status and mask registers.
  localparam int EVT_UV        = 0;
  localparam int EVT_OC        = 1;
  localparam int EVT_OV        = 2;
  localparam int EVT_SUPPLY    = 3;

  // Implemented bits of each register, with the live supply bit left out of MASK_FLAG_TWO; all other bits read as zero.
  localparam logic [7:0] MASK_CTRL     = 8'hc0;
  localparam logic [7:0] MASK_ONE      = 8'h73;
  localparam logic [7:0] MASK_TWO      = 8'hb2;
  localparam logic [7:0] MASK_FLAG_TWO = 8'hb0;
  localparam logic [7:0] MASK_EVT      = 8'h0f;

  // Reset values.
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [3:0] RST_LEVELS    = 4'h0;

endpackage

/* File: hdl/pife_sync3.sv */
// Three-stage synchroniser with agreement filter for asynchronous level inputs.
`timescale 1ns/10ps
module pife_sync3 #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Levels from outside the clock domain and their filtered copy.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  import pife_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } pife_sync_t;

  pife_sync_t sync_reg;
  pife_sync_t sync_next;

  // Stage one feeds only stage two; a level change is taken once stages two and three agree.
  always_comb
  begin
    sync_next        = sync_reg;
    sync_next.stage1 = async_in;
    sync_next.stage2 = sync_reg.stage1;
    sync_next.stage3 = sync_reg.stage2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (sync_reg.stage2[i] == sync_reg.stage3[i])
      begin
        sync_next.level[i] = sync_reg.stage3[i];
      end
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign level_out = sync_reg.level;

endmodule

/* File: dv/pife_core_model.sv */
// Behavioural model of the core side that enters and leaves the service routine.
`timescale 1ns/10ps
module pife_core_model (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst,
  // Request from the block and end of service from the bench.
  input  wire logic core_irq_req,
  input  wire logic isr_done,
  // Handshake toward the block.
  output logic      core_irq_taken,
  output logic      core_irq_return
);
  logic in_isr;

  // Enter once per request; return only after the bench has serviced the flags.
  // A flag left set would raise the request again right after the return.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      in_isr          <= 1'b0;
      core_irq_taken  <= 1'b0;
      core_irq_return <= 1'b0;
    end
    else
    begin
      core_irq_taken  <= !in_isr && core_irq_req && !core_irq_taken;
      core_irq_return <= in_isr && isr_done;
      if (!in_isr && core_irq_req && !core_irq_taken)
        in_isr <= 1'b1;
      else if (in_isr && isr_done)
        in_isr <= 1'b0;
    end
  end
endmodule

/* File: dv/pife_top_tb_top.sv */
// Self-checking bench for the peripheral interrupt block and its core model.
`timescale 1ns/10ps
module pife_top_tb_top;
  import pife_pkg::*;
  logic       clk_sys   = 1'b0;
  logic       rst       = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] ev_vec    = 5'h00;
  logic [3:0] flt       = 4'h0;
  logic       isr_done  = 1'b0;
  logic       periph_req;
  logic       core_irq_req;
  logic       fault_irq;
  logic       core_irq_taken;
  logic       core_irq_return;
  int         error_cnt = 0;
  int         checks    = 0;
  int         cyc       = 0;

  always #20 clk_sys = ~clk_sys;

  // Event vector is adc, collision, serial, timer two, timer one; fault vector is uv, oc, ov, supply.
  pife_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_done(ev_vec[4]),
    .serial_port_event(ev_vec[2]), .bus_collision_event(ev_vec[3]), .timer_two_match(ev_vec[1]),
    .timer_one_rollover(ev_vec[0]), .out_undervolt(flt[3]), .out_overcurrent(flt[2]),
    .out_overvolt(flt[1]), .supply_low(flt[0]), .core_irq_taken(core_irq_taken),
    .core_irq_return(core_irq_return), .periph_req(periph_req), .core_irq_req(core_irq_req),
    .fault_irq(fault_irq));

  pife_core_model core (.clk_sys(clk_sys), .rst(rst), .core_irq_req(core_irq_req), .isr_done(isr_done),
    .core_irq_taken(core_irq_taken), .core_irq_return(core_irq_return));

  // Places each event of the vector at its flag position in the first flag register.
  function automatic logic [7:0] fmap(input logic [4:0] v);
    return {1'b0, v[4], v[3], v[2], 2'b00, v[1], v[0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Each bus task waits an edge first, so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge clk_sys);
    ev_vec <= v;
    @(posedge clk_sys);
    ev_vec <= 5'h00;
    #1;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset();
    for (int a = 0; a < 8; a++)
      rdchk(a[3:0], 8'h00);
    chk("outputs", {5'h00, periph_req, core_irq_req, fault_irq}, 8'h00);
  endtask

  task automatic t_access();
    logic [3:0] adr [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
    logic [7:0] msk [7] = '{8'hc0, 8'h73, 8'hb2, 8'h73, 8'hb0, 8'h0f, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      wr(adr[i], 8'hff);
      rdchk(adr[i], msk[i]);
      wr(adr[i], 8'h00);
      rdchk(adr[i], 8'h00);
    end
  endtask

  task automatic t_flags();
    logic [4:0] acc;
    acc = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      pulse(5'h01 << i);
      acc = acc | (5'h01 << i);
      rdchk(4'h3, fmap(acc));
      chk("periph_req", {7'h00, periph_req}, 8'h00);
    end
    wr(4'h3, 8'h00);
    rdchk(4'h3, 8'h00);
  endtask

  task automatic t_gate();
    wr(4'h0, 8'h40);
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h1, fmap(5'h01 << i));
      pulse(5'h01 << ((i + 1) % 5));
      chk("other source", {7'h00, periph_req}, 8'h00);
      pulse(5'h01 << i);
      chk("own source", {7'h00, periph_req}, 8'h01);
      chk("no global", {7'h00, core_irq_req}, 8'h00);
      wr(4'h3, 8'h00);
      chk("cleared", {7'h00, periph_req}, 8'h00);
    end
    wr(4'h1, 8'h01);
    pulse(5'h01);
    wr(4'h0, 8'h00);
    chk("group off", {7'h00, periph_req}, 8'h00);
  endtask

  task automatic t_core();
    wr(4'h0, 8'hc0);
    chk("core req", {6'h00, periph_req, core_irq_req}, 8'h03);
    settle(3);
    chk("taken", {7'h00, core_irq_req}, 8'h00);
    rdchk(4'h0, 8'h40);
    wr(4'h3, 8'h00);
    @(posedge clk_sys);
    isr_done <= 1'b1;
    @(posedge clk_sys);
    isr_done <= 1'b0;
    settle(3);
    rdchk(4'h0, 8'hc0);
    chk("after return", {7'h00, core_irq_req}, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
  endtask

  task automatic t_race();
    pulse(5'h02);
    @(posedge clk_sys);
    reg_addr  <= 4'h3;
    reg_wdata <= 8'h00;
    reg_wr    <= 1'b1;
    ev_vec    <= 5'h05;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    ev_vec <= 5'h00;
    rdchk(4'h3, 8'h11);
    wr(4'h3, 8'h00);
  endtask

  task automatic t_fault();
    wr(4'h6, 8'h02);
    wr(4'h2, 8'h20);
    wr(4'h0, 8'h40);
    @(posedge clk_sys);
    flt <= 4'he;
    settle(6);
    chk("fault outs", {6'h00, fault_irq, periph_req}, 8'h03);
    rdchk(4'h4, 8'hb0);
    rdchk(4'h5, 8'h07);
    @(posedge clk_sys);
    flt <= 4'h1;
    settle(6);
    rdchk(4'h4, 8'hb2);
    wr(4'h5, 8'h0f);
    chk("fault cleared", {7'h00, fault_irq}, 8'h00);
    @(posedge clk_sys);
    flt <= 4'h0;
    settle(6);
    rdchk(4'h4, 8'hb0);
    wr(4'h4, 8'h00);
    rdchk(4'h4, 8'h00);
    chk("fault req", {7'h00, periph_req}, 8'h00);
    wr(4'h0, 8'h00);
  endtask

  // A reset in mid-run must clear enables, flags and the global enable that were all set.
  task automatic t_rerun();
    wr(4'h0, 8'hc0);
    wr(4'h1, 8'h73);
    pulse(5'h1f);
    @(posedge clk_sys);
    rst <= 1'b1;
    settle(3);
    @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
  endtask

  // A hung handshake is cut short at cycle 5000, long after the real run length would be reached.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    $display("test reset done");
    t_access();
    $display("test access done");
    t_flags();
    $display("test flags done");
    t_gate();
    $display("test gating done");
    t_core();
    $display("test core done");
    t_race();
    $display("test race done");
    t_fault();
    $display("test fault done");
    t_rerun();
    $display("test rerun done");
    print_verdict();
  end
endmodule
